// ===== core/multichannel_hall_pattern_switch.v
// Purpose: multi-channel output pattern and hall pattern compare logic
// Assumes: timer events are one-cycle pulses synchronous to ref_clk
// Notes:   registers reached over Avalon-MM, one wait state on every access
//
// The Avalon-MM interface to the registers and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "hall_pattern_defines.vh"

// Notes on behaviour
// - with multichannel enabled, output active only where pattern bit is 1
// - shadow pattern copied to active only on event transfer or software request
// - event select 000 none, 001 correct position, 010 aux period match
// - 011 main one-match down, 100 ch1 compare up, 101 main period up
// - sync 00 direct, 01 aux zero-match, 10 main zero-match, 11 nothing
// - synchronised update applied only at start of new timer period
// - reminder flag set by selected event, cleared by transfer, readable
// - every pattern transfer sets transfer status flag
// - shadow write with request bit forces transfer under any event select
// - direct sync with request bit gives pure software-controlled update
// - main and aux timer shadow transfers may accompany pattern transfer
// - three position inputs give the rotor position
// - one register holds current, expected and output pattern, with shadow
// - new pattern output when sampled inputs equal expected pattern
// - inputs compared to both expected and current patterns
// - optional sampling delay before comparison
// - correct change copies shadow to active; software may force it
// - input 0 is bit 0, input 2 is bit 2 of position fields
// - match current is spike, match expected correct, neither wrong
// - while halt flag set active output pattern is cleared
// - transfer interrupt pulse on every set event, even if flag set
module multichannel_hall_pattern_switch #(
  parameter DELAY_W = `DELAY_W
) (
  input  wire        ref_clk,
  input  wire        resetn,
  input  wire [2:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        position_input_0,
  input  wire        position_input_1,
  input  wire        position_input_2,
  input  wire        aux_period_match,
  input  wire        main_one_match,
  input  wire        main_period_match,
  input  wire        channel1_compare_match,
  input  wire        count_direction,
  input  wire        aux_zero_match,
  input  wire        main_zero_match,
  input  wire [5:0]  timer_outputs,
  output reg  [5:0]  gated_outputs,
  output reg         pattern_shadow_transfer,
  output reg         main_timer_shadow_transfer,
  output reg         aux_timer_shadow_transfer,
  output reg         correct_position_event,
  output reg         wrong_position_event,
  output reg         transfer_irq
);

  // active and shadow patterns
  reg  [5:0]         output_enable_pattern;
  reg  [5:0]         output_enable_pattern_shadow;
  reg  [2:0]         current_position_pattern;
  reg  [2:0]         expected_position_pattern;
  reg  [2:0]         currentShadow;
  reg  [2:0]         expectedShadow;
  // control
  reg  [2:0]         switch_event_select;
  reg  [1:0]         switch_sync_select;
  reg                steMain;
  reg                steAux;
  reg                multichannel_enable;
  reg                reminder;
  // status
  reg                correctFlag;
  reg                wrongFlag;
  reg                pattern_transfer_flag;
  reg                haltFlag;
  reg                haltEnable;
  // position sampling; lastSample holds the inputs of the previous cycle
  reg  [2:0]         lastSample;
  reg  [DELAY_W-1:0] delayCount;
  reg  [DELAY_W-1:0] delaySetting;
  reg                delayBusy;
  reg                samplePrimed;
  // software transfer requests (one cycle)
  reg                swMcmRequest;
  reg                swHpRequest;

  // write strobe for one word index; the control, modulation, status and clear
  // strobes decode through this, so a changed map only touches the defines header
  function wrHit;
    input       acc;
    input [2:0] addr;
    input [2:0] idx;
    begin
      wrHit = acc & (addr == idx);
    end
  endfunction

  wire [2:0] position_inputs = {position_input_2, position_input_1, position_input_0};
  // a write lands only at the edge where waitrequest is sampled low
  wire       accWrite = avs_write & ~avs_waitrequest;
  wire       wrShadow = avs_write & (avs_address == `REG_PATTERN_SHADOW) & avs_byteenable[0];
  wire       ctlWrite = wrHit(accWrite, avs_address, `REG_SWITCH_CONTROL);
  wire       modWrite = wrHit(accWrite, avs_address, `REG_MODULATION_CTRL);
  wire       statWrite = wrHit(accWrite, avs_address, `REG_IRQ_STATUS) & avs_byteenable[0];
  wire       clrWrite = wrHit(accWrite, avs_address, `REG_IRQ_CLEAR);

  // evaluation strobe: edge seen, optionally delayed for noise immunity;
  // no edge is taken before the first sample after reset, since the reset
  // value of lastSample says nothing about where the rotor really stands
  wire       inputEdge = samplePrimed & (position_inputs != lastSample);
  wire       evalNow = delayBusy ? (delayCount == {DELAY_W{1'b0}})
                                 : (inputEdge & (delaySetting == {DELAY_W{1'b0}}));
  // a match with the current pattern is a spike and is dropped silently
  wire       matchCur = (position_inputs == current_position_pattern);
  wire       matchExp = (position_inputs == expected_position_pattern);
  wire       correctEv = evalNow & ~matchCur & matchExp;
  wire       wrongEv = evalNow & ~matchCur & ~matchExp;

  // selected switching event decode; dir is high while the main timer
  // counts down, and codes 110 and 111 never fire
  function selEvent;
    input [2:0] sel;
    input       che;
    input       apm;
    input       mom;
    input       c1m;
    input       mpm;
    input       dir;
    begin
      case (sel)
        `SEL_CORRECT: selEvent = che;
        `SEL_AUXPM:   selEvent = apm;
        `SEL_MAINOM:  selEvent = mom & dir;
        `SEL_CH1CM:   selEvent = c1m & ~dir;
        `SEL_MAINPM:  selEvent = mpm & ~dir;
        default:      selEvent = 1'b0;
      endcase
    end
  endfunction

  // the selected event, already qualified by count direction
  wire swEvent = selEvent(switch_event_select, correctEv, aux_period_match, main_one_match,
                          channel1_compare_match, main_period_match, count_direction);
  // armed: an event in this cycle or one still waiting from an earlier cycle
  wire armed = reminder | swEvent;
  reg  syncHit;

  // sync qualifier: a pending event only fires at the chosen period start;
  // an event between two zero-matches waits in the reminder flag
  always @* begin
    case (switch_sync_select)
      `SYN_DIRECT: syncHit = armed;
      `SYN_AUXZM:  syncHit = armed & aux_zero_match;
      `SYN_MAINZM: syncHit = armed & main_zero_match;
      default:     syncHit = 1'b0;
    endcase
  end

  // a software request bypasses event select and sync, so the pattern can be
  // forced at any time outside halt, with or without a running timer
  wire mcmTransfer = syncHit | swMcmRequest;
  // position patterns move on a correct event or on their own request bit
  wire hpTransfer = correctEv | swHpRequest;

  // sampling and delay counter; a change seen while the delay runs does not
  // restart it, so a spike that settles back inside the window is judged
  // against the pattern that stands when the window closes
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lastSample <= 3'h0;
      samplePrimed <= 1'b0;
      delayCount <= {DELAY_W{1'b0}};
      delayBusy <= 1'b0;
    end else begin
      lastSample <= position_inputs;
      samplePrimed <= 1'b1;
      if (delayBusy) begin
        if (delayCount == {DELAY_W{1'b0}})
          delayBusy <= 1'b0;
        else
          delayCount <= delayCount - 1'b1;
      end else if (inputEdge && delaySetting != {DELAY_W{1'b0}}) begin
        // a zero setting takes the edge at once and never starts the counter
        delayBusy <= 1'b1;
        delayCount <= delaySetting - 1'b1;
      end
    end
  end

  // pattern registers, shadows and reminder
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      output_enable_pattern <= `RST_PATTERN;
      output_enable_pattern_shadow <= `RST_PATTERN;
      current_position_pattern <= `RST_POS;
      expected_position_pattern <= `RST_POS;
      currentShadow <= `RST_POS;
      expectedShadow <= `RST_POS;
      reminder <= 1'b0;
    end else begin
      if (accWrite && wrShadow) begin
        output_enable_pattern_shadow <= avs_writedata[`OEP_MSB:`OEP_LSB];
      end
      if (accWrite && avs_address == `REG_PATTERN_SHADOW && avs_byteenable[1]) begin
        expectedShadow <= avs_writedata[`EXP_MSB:`EXP_LSB];
        currentShadow <= avs_writedata[`CUR_MSB:`CUR_LSB];
      end
      // halt clears the active pattern (passive outputs with multichannel enabled) and wins over any transfer;
      // leaving halt does not restore the old pattern, a software or event transfer must load a new one
      if (haltFlag)
        output_enable_pattern <= 6'h00;
      else if (mcmTransfer)
        output_enable_pattern <= output_enable_pattern_shadow;
      // position patterns follow a correct event even with event select off,
      // so the compare keeps tracking the rotor while the outputs are frozen
      if (hpTransfer) begin
        current_position_pattern <= currentShadow;
        expected_position_pattern <= expectedShadow;
      end
      // reminder: the transfer is the clear, and an event in the same cycle is
      // the one served by that transfer, so it must not re-arm the flag;
      // in direct mode the event fires at once and the flag never shows
      if (mcmTransfer)
        reminder <= 1'b0;
      else if (swEvent)
        reminder <= 1'b1;
    end
  end

  // control registers and one-cycle software requests; the request bits are
  // write-only strobes and read back as zero
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      switch_event_select <= `SEL_NONE;
      switch_sync_select <= `SYN_DIRECT;
      steMain <= 1'b0;
      steAux <= 1'b0;
      multichannel_enable <= 1'b0;
      delaySetting <= {DELAY_W{1'b0}};
      swMcmRequest <= 1'b0;
      swHpRequest <= 1'b0;
    end else begin
      swMcmRequest <= accWrite & wrShadow & avs_writedata[`STR_MCM_BIT];
      swHpRequest <= accWrite & (avs_address == `REG_PATTERN_SHADOW)
                     & avs_byteenable[2] & avs_writedata[`STR_HP_BIT];
      if (ctlWrite) begin
        if (avs_byteenable[0]) begin
          switch_event_select <= avs_writedata[`SWITCH_EVENT_SELECT_MSB:`SWITCH_EVENT_SELECT_LSB];
          switch_sync_select <= avs_writedata[`SWITCH_SYNC_SELECT_MSB:`SWITCH_SYNC_SELECT_LSB];
        end
        if (avs_byteenable[1]) begin
          steMain <= avs_writedata[`STE_MAIN_BIT];
          steAux <= avs_writedata[`STE_AUX_BIT];
        end
      end
      if (modWrite && avs_byteenable[0]) begin
        multichannel_enable <= avs_writedata[`MCEN_BIT];
        delaySetting <= avs_writedata[DELAY_W-1:0];
      end
    end
  end

  // status flags: hardware set wins over software clear, so an event that
  // lands in the clear cycle is never lost
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      correctFlag <= 1'b0;
      wrongFlag <= 1'b0;
      pattern_transfer_flag <= 1'b0;
      haltFlag <= 1'b0;
      haltEnable <= 1'b0;
    end else begin
      if (correctEv)
        correctFlag <= 1'b1;
      else if (clrWrite && avs_writedata[`ST_CORRECT])
        correctFlag <= 1'b0;
      if (wrongEv)
        wrongFlag <= 1'b1;
      else if (clrWrite && avs_writedata[`ST_WRONG])
        wrongFlag <= 1'b0;
      // transfer flag and its request pulse share one set strobe
      if (mcmTransfer)
        pattern_transfer_flag <= 1'b1;
      else if (clrWrite && avs_writedata[`ST_TRANSFER])
        pattern_transfer_flag <= 1'b0;
      // a wrong event sets the halt flag only when software has armed it
      if (wrongEv && haltEnable)
        haltFlag <= 1'b1;
      else if (clrWrite && avs_writedata[`ST_HALT])
        haltFlag <= 1'b0;
      if (statWrite) begin
        haltEnable <= avs_writedata[`ST_HALTEN];
        if (avs_writedata[`ST_HALT])
          haltFlag <= 1'b1;
      end
    end
  end

  // outputs, all registered; each pulse trails its internal event by one
  // cycle, and gating uses the pattern that stood before the edge
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      gated_outputs <= 6'h00;
      pattern_shadow_transfer <= 1'b0;
      main_timer_shadow_transfer <= 1'b0;
      aux_timer_shadow_transfer <= 1'b0;
      correct_position_event <= 1'b0;
      wrong_position_event <= 1'b0;
      transfer_irq <= 1'b0;
    end else begin
      gated_outputs <= multichannel_enable ? (timer_outputs & output_enable_pattern)
                                           : timer_outputs;
      pattern_shadow_transfer <= mcmTransfer;
      // timer shadow transfers ride on the pattern transfer, so duty cycle
      // and pattern change in the same period
      main_timer_shadow_transfer <= mcmTransfer & steMain;
      aux_timer_shadow_transfer <= mcmTransfer & steAux;
      correct_position_event <= correctEv;
      wrong_position_event <= wrongEv;
      transfer_irq <= mcmTransfer;
    end
  end

  // read data: captured in the first cycle of a read, while waitrequest is
  // still high, and left standing so it is valid in the cycle that ends it
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h00000000;
    end else begin
      if (avs_read && avs_waitrequest) begin
        case (avs_address)
          `REG_PATTERN_ACTIVE:
            avs_readdata <= {18'h00000, current_position_pattern, expected_position_pattern,
                             2'h0, output_enable_pattern};
          `REG_PATTERN_SHADOW:
            avs_readdata <= {18'h00000, currentShadow, expectedShadow,
                             2'h0, output_enable_pattern_shadow};
          `REG_SWITCH_CONTROL:
            avs_readdata <= {19'h00000, reminder, 2'h0, steAux, steMain,
                             2'h0, switch_sync_select, 1'b0, switch_event_select};
          `REG_MODULATION_CTRL:
            avs_readdata <= {24'h000000, multichannel_enable, {(7-DELAY_W){1'b0}},
                             delaySetting};
          `REG_IRQ_STATUS:
            avs_readdata <= {24'h000000, 3'h0, haltEnable, haltFlag, pattern_transfer_flag,
                             wrongFlag, correctFlag};
          // unmapped words and the write-only clear word read back as zero
          default:
            avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // waitrequest from a flop: high while idle, low for exactly one cycle once
  // a request has been seen; this costs one wait state on writes as well,
  // but keeps every port on a register and gives the read data a full cycle
  // to settle before the master takes it
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
    end
  end

endmodule // multichannel_hall_pattern_switch
`default_nettype wire

// ===== core/hall_pattern_defines.vh
// Purpose: register map, field positions and reset values of the pattern switch
// Assumes: Avalon-MM word addressing, 32-bit data
// Notes:   every offset is a byte address divided by four
`ifndef HALL_PATTERN_DEFINES_VH
`define HALL_PATTERN_DEFINES_VH

// register indices (word address)
`define REG_PATTERN_ACTIVE   3'h0
`define REG_PATTERN_SHADOW   3'h1
`define REG_SWITCH_CONTROL   3'h2
`define REG_MODULATION_CTRL  3'h3
`define REG_IRQ_STATUS       3'h4
`define REG_IRQ_CLEAR        3'h5

// pattern register fields
`define OEP_LSB      0
`define OEP_MSB      5
`define EXP_LSB      8
`define EXP_MSB      10
`define CUR_LSB      11
`define CUR_MSB      13
`define STR_MCM_BIT  16
`define STR_HP_BIT   17

// switch control fields
`define SWITCH_EVENT_SELECT_LSB    0
`define SWITCH_EVENT_SELECT_MSB    2
`define SWITCH_SYNC_SELECT_LSB    4
`define SWITCH_SYNC_SELECT_MSB    5
`define STE_MAIN_BIT 8
`define STE_AUX_BIT  9
`define REMIND_BIT   12

// modulation control
`define MCEN_BIT     7

// status bits
`define ST_CORRECT   0
`define ST_WRONG     1
`define ST_TRANSFER  2
`define ST_HALT      3
`define ST_HALTEN    4

// switching event select codes
`define SEL_NONE     3'h0
`define SEL_CORRECT  3'h1
`define SEL_AUXPM    3'h2
`define SEL_MAINOM   3'h3
`define SEL_CH1CM    3'h4
`define SEL_MAINPM   3'h5

// switching sync codes
`define SYN_DIRECT   2'h0
`define SYN_AUXZM    2'h1
`define SYN_MAINZM   2'h2

// reset values
`define RST_PATTERN  6'h00
`define RST_POS      3'h0

// sampling delay
`define DELAY_W      4

`endif

// ===== verif/hall_pattern_chk.sv
// Purpose: port-level checks for the pattern switch
// Assumes: master holds each request until waitrequest is low
// Notes:   control fields stay internal, so only port relations here
`timescale 1ns/100ps
`default_nettype none
module hall_pattern_chk (
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic [2:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  input wire logic [5:0]  timer_outputs,
  input wire logic [5:0]  gated_outputs,
  input wire logic        pattern_shadow_transfer,
  input wire logic        correct_position_event,
  input wire logic        wrong_position_event,
  input wire logic        transfer_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // first read cycle, then a software transfer request
  sequence s_rd_wait;
    avs_read && avs_waitrequest;
  endsequence
  sequence s_sw_req;
    avs_write && !avs_waitrequest && avs_address == 3'h1 && avs_byteenable[0]
      && avs_writedata[16];
  endsequence
  property p_rd_first; $rose(avs_read) |-> avs_waitrequest; endproperty
  a_rd_first: assert property (p_rd_first) else $error("read not held one cycle");
  property p_rd_done; s_rd_wait |=> !avs_waitrequest; endproperty
  a_rd_done: assert property (p_rd_done) else $error("read wait too long");
  property p_wr_wait; avs_write && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_wr_wait: assert property (p_wr_wait) else $error("write wait too long");
  property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
  // an output never turns on where the timer output is passive
  property p_gate; (gated_outputs & ~$past(timer_outputs)) == 6'h00; endproperty
  a_gate: assert property (p_gate) else $error("output active without timer");
  property p_sw; s_sw_req |-> ##2 pattern_shadow_transfer; endproperty
  a_sw: assert property (p_sw) else $error("requested transfer missing");
  property p_pulse; pattern_shadow_transfer |=> !pattern_shadow_transfer; endproperty
  a_pulse: assert property (p_pulse) else $error("transfer pulse too long");
  property p_irq; pattern_shadow_transfer |-> transfer_irq; endproperty
  a_irq: assert property (p_irq) else $error("transfer without request");
  property p_excl; !(correct_position_event && wrong_position_event); endproperty
  a_excl: assert property (p_excl) else $error("correct and wrong together");
endmodule // hall_pattern_chk
`default_nettype wire

// ===== verif/position_sensor_model.sv
// Purpose: rotor position sensor stand-in
// Assumes: bench picks the sector code
// Notes:   all lines move on one edge, no bounce modelled
`timescale 1ns/100ps
`default_nettype none
module position_sensor_model (
  input  wire logic       ref_clk,
  input  wire logic [2:0] sector,
  output var  logic [2:0] lines
);
  // synchronised sensor: line n carries bit n of the sector
  initial lines = 3'h0;
  always @(posedge ref_clk) lines <= sector;
endmodule // position_sensor_model
`default_nettype wire

// ===== verif/multichannel_hall_pattern_switch_test.sv
// Purpose: self-checking bench for the pattern switch
// Assumes: waitrequest seen low ends each bus cycle
// Notes:   expectations follow the field layout only
`timescale 1ns/100ps
`default_nettype none
module multichannel_hall_pattern_switch_test;
  logic        refClk = 1'b0;
  logic        resetn = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic        rdReq = 1'b0;
  logic        wrReq = 1'b0;
  logic [31:0] wrData = 32'h0;
  logic [31:0] rdData;
  logic        waitReq;
  logic [5:0]  ev = 6'h00;
  logic        dir = 1'b0;
  logic [5:0]  tmrOut = 6'h00;
  logic [5:0]  gated;
  logic [2:0]  sector = 3'h1;
  logic [2:0]  pos;
  logic [5:0]  pul;
  logic [31:0] r;
  logic [5:0]  act;
  logic [5:0]  pat;
  logic        hit;
  int          n;
  int          failures = 0;
  int          checks_done = 0;
  int          cnt[6] = '{0, 0, 0, 0, 0, 0};
  // 100 ns clock
  always #50 refClk = ~refClk;
  // pulse counters; nonblocking so a read at an edge sees the old count
  always @(posedge refClk) begin
    for (int i = 0; i < 6; i++)
      cnt[i] <= cnt[i] + (pul[i] === 1'b1);
  end
  multichannel_hall_pattern_switch u_multichannel_hall_pattern_switch (
    .ref_clk(refClk), .resetn(resetn), .avs_address(addr), .avs_read(rdReq),
    .avs_write(wrReq), .avs_writedata(wrData), .avs_byteenable(4'hf),
    .avs_readdata(rdData), .avs_waitrequest(waitReq), .position_input_0(pos[0]),
    .position_input_1(pos[1]), .position_input_2(pos[2]), .aux_period_match(ev[0]),
    .main_one_match(ev[1]), .main_period_match(ev[2]), .channel1_compare_match(ev[3]),
    .count_direction(dir), .aux_zero_match(ev[4]), .main_zero_match(ev[5]),
    .timer_outputs(tmrOut), .gated_outputs(gated), .pattern_shadow_transfer(pul[0]),
    .main_timer_shadow_transfer(pul[4]), .aux_timer_shadow_transfer(pul[5]),
    .correct_position_event(pul[1]), .wrong_position_event(pul[2]), .transfer_irq(pul[3])
  );
  position_sensor_model u_position_sensor_model (
    .ref_clk(refClk), .sector(sector), .lines(pos)
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one bus cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    @(posedge refClk);
    addr <= a;
    wrData <= d;
    wrReq <= wr;
    rdReq <= !wr;
    do @(posedge refClk); while (waitReq !== 1'b0);
    r = rdData;
    wrReq <= 1'b0;
    rdReq <= 1'b0;
  endtask
  // one-cycle timer event, then a short settle
  task automatic pulse(input int i, input logic d);
    @(posedge refClk);
    ev[i] <= 1'b1;
    dir <= d;
    @(posedge refClk);
    ev <= 6'h00;
    repeat (3) @(posedge refClk);
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // run is about a thousand cycles; a hang ends here
  initial begin
    #1000000;
    failures++;
    give_verdict();
  end
  initial begin
    repeat (6) @(posedge refClk);
    resetn <= 1'b1;
    bus(1'b0, 3'h0, 32'h0); check(r, 32'h0);
    bus(1'b0, 3'h1, 32'h0); check(r, 32'h0);
    $display("reset test done");
    // software transfer of all fields, both timer shadow transfers enabled
    bus(1'b1, 3'h2, 32'h0000_0300);
    bus(1'b1, 3'h1, 32'h0003_0b2a);
    bus(1'b0, 3'h0, 32'h0); check(r, 32'h0000_0b2a);
    bus(1'b0, 3'h4, 32'h0); check(r[2], 1'b1);
    check(cnt[0], 32'h1);
    check(cnt[4], 32'h1);
    check(cnt[5], 32'h1);
    bus(1'b1, 3'h3, 32'h80);
    tmrOut <= 6'h3f;
    repeat (2) @(posedge refClk);
    check(gated, 6'h2a);
    $display("software test done");
    // every select code against the four period and compare events (ev 0 to 3) and both directions
    act = 6'h2a;
    for (int c = 0; c < 8; c++) begin
      for (int e = 0; e < 8; e++) begin
        hit = (c == 2 && e < 2) || (c == 3 && e == 3) || (c == 5 && e == 4) || (c == 4 && e == 6);
        pat = ~act;
        bus(1'b1, 3'h2, c);
        bus(1'b1, 3'h1, {26'h0, pat});
        pulse(e / 2, e[0]);
        if (hit)
          act = pat;
        bus(1'b0, 3'h0, 32'h0); check(r[5:0], act);
      end
    end
    $display("select test done");
    // synchronised modes: event alone only arms the reminder
    for (int s = 1; s < 4; s++) begin
      pat = ~act;
      bus(1'b1, 3'h2, 32'h2 | (s << 4));
      bus(1'b1, 3'h1, {26'h0, pat});
      pulse(0, 1'b0);
      bus(1'b0, 3'h2, 32'h0);
      if (s < 3)
        check(r[12], 1'b1);
      bus(1'b0, 3'h0, 32'h0); check(r[5:0], act);
      pulse(s == 1 ? 4 : 5, 1'b0);
      if (s < 3)
        act = pat;
      bus(1'b0, 3'h0, 32'h0); check(r[5:0], act);
      if (s < 3) begin
        bus(1'b0, 3'h2, 32'h0); check(r[12], 1'b0);
      end
    end
    $display("sync test done");
    // position change to expected pattern, sampling delay 3
    bus(1'b1, 3'h3, 32'h83);
    bus(1'b1, 3'h2, 32'h1);
    bus(1'b1, 3'h1, 32'h0003_0b05);
    bus(1'b1, 3'h1, 32'h0000_1a06);
    sector <= 3'h3;
    n = 0;
    do begin
      @(posedge refClk);
      n++;
    end while (cnt[1] == 0 && n < 50);
    check(n > 4, 1'b1);
    check(cnt[1], 32'h1);
    bus(1'b0, 3'h0, 32'h0); check(r, 32'h0000_1a06);
    sector <= 3'h6;
    repeat (12) @(posedge refClk);
    check(cnt[2], 32'h1);
    sector <= 3'h3;
    repeat (12) @(posedge refClk);
    check(cnt[1] + cnt[2], 32'h2);
    $display("position test done");
    // halt clears the active pattern
    bus(1'b1, 3'h4, 32'h10);
    bus(1'b1, 3'h4, 32'h18);
    bus(1'b0, 3'h0, 32'h0); check(r[5:0], 6'h00);
    check(gated, 6'h00);
    check(cnt[3], cnt[0]);
    check(cnt[5], 32'h1);
    $display("halt test done");
    give_verdict();
  end
endmodule // multichannel_hall_pattern_switch_test
bind multichannel_hall_pattern_switch hall_pattern_chk u_hall_pattern_chk (.*);
`default_nettype wire
